// ### cfg_pkg.sv
`default_nettype none
package cfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int CH_COUNT = 2;
    localparam int CODE_W = 12;
    localparam int CODE_LSB = 4;
    localparam int CODE_MSB = 15;
    localparam int NARROW_DROP = 2;

    localparam logic [7:0] ADDR_CH1_HIGH = 8'h01;
    localparam logic [7:0] ADDR_CH1_LOW = 8'h02;
    localparam logic [7:0] ADDR_CH1_GAIN_CMP = 8'h03;
    localparam logic [7:0] ADDR_CH1_IRANGE = 8'h04;
    localparam logic [7:0] ADDR_CH1_CMP_FUNC = 8'h05;
    localparam logic [7:0] ADDR_CH0_HIGH = 8'h13;
    localparam logic [7:0] ADDR_CH0_LOW = 8'h14;
    localparam logic [7:0] ADDR_CH0_GAIN_CMP = 8'h15;
    localparam logic [7:0] ADDR_CH0_IRANGE = 8'h16;
    localparam logic [7:0] ADDR_CH0_CMP_FUNC = 8'h17;

    localparam logic [7:0] PMBUS_CFG_PAGE = 8'hFF;
    localparam logic [7:0] PMBUS_CH0_GAIN_CMP = 8'hDD;
    localparam logic [7:0] PMBUS_CH0_IRANGE = 8'hDE;
    localparam logic [7:0] PMBUS_CH0_CMP_FUNC = 8'hDF;
    localparam logic [7:0] PMBUS_CH1_GAIN_CMP = 8'hD1;
    localparam logic [7:0] PMBUS_CH1_IRANGE = 8'hD2;
    localparam logic [7:0] PMBUS_CH1_CMP_FUNC = 8'hD3;

    localparam logic [15:0] RESET_VALUE = 16'h0000;
    localparam logic [15:0] MASK_CODE = 16'hFFF0;
    localparam logic [15:0] MASK_GAIN_CMP = 16'h1C1F;
    localparam logic [15:0] MASK_IRANGE = 16'h1E00;
    localparam logic [15:0] MASK_CMP_FUNC = 16'h0C00;

    localparam int GAIN_LSB = 10;
    localparam int GAIN_MSB = 12;
    localparam int BIT_OPEN_DRAIN = 4;
    localparam int BIT_PIN_ROUTE = 3;
    localparam int BIT_DIVIDER = 2;
    localparam int BIT_INVERT = 1;
    localparam int BIT_ENABLE = 0;
    localparam int IRANGE_LSB = 9;
    localparam int IRANGE_MSB = 12;
    localparam int FUNC_LSB = 10;
    localparam int FUNC_MSB = 11;

    typedef enum logic [2:0] {
        GAIN_1X_EXT = 3'h0,
        GAIN_1X_SUPPLY = 3'h1,
        GAIN_1P5X_INT = 3'h2,
        GAIN_2X_INT = 3'h3,
        GAIN_3X_INT = 3'h4,
        GAIN_4X_INT = 3'h5
    } gain_e;

    typedef enum logic [3:0] {
        IRANGE_25UA = 4'h8,
        IRANGE_50UA = 4'h9,
        IRANGE_125UA = 4'hA,
        IRANGE_250UA = 4'hB
    } irange_e;

    typedef enum logic [1:0] {
        FUNC_PLAIN = 2'h0,
        FUNC_HYSTERESIS = 2'h1,
        FUNC_WINDOW = 2'h2
    } func_e;
endpackage
`default_nettype wire

// ### cfg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cfg_if;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;

    modport device (
        input addr,
        input wdata,
        input wr,
        input rd,
        output rdata
    );
    modport host (
        output addr,
        output wdata,
        output wr,
        output rd,
        input rdata
    );
endinterface
`default_nettype wire

// ### cfg_device.sv
// Behaviour
// - Lower margin code in bits 15:4, left aligned.
// - Bits 3:0 of margin code ignored, zero.
// - Gain select bits 12:10 decode six codes.
// - Bit 4 open-drain only when comparator routed.
// - Bit 3 routes comparator result to pin; cfg_device routes it only while bit 0 enable is set.
// - Bit 2 connects feedback resistor divider.
// - Bit 1 inverts comparator result.
// - Host enables comparator only with voltage output; cfg_host passes any enable write through unchecked.
// - Current range bits 12:9 decode four codes.
// - Function code 00 gives plain comparator.
// - Function code 01 applies hysteresis thresholds.
// - Function code 10 gives window comparator.
// - Gain/comparator register resets to zero.
// - Gain/comparator at 15h and 03h.
// - Current range at 16h and 04h.
// - Comparator function at 17h and 05h.
// - Upper margin code at 13h and 01h.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module cfg_device #(
    parameter int NARROW = 0
) (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    cfg_if.device BUS,
    input wire logic [1:0] I_CMP_RAW,
    output logic [11:0] O_CH0_UPPER_CODE,
    output logic [11:0] O_CH0_LOWER_CODE,
    output logic [11:0] O_CH1_UPPER_CODE,
    output logic [11:0] O_CH1_LOWER_CODE,
    output logic [2:0] O_CH0_GAIN,
    output logic [2:0] O_CH1_GAIN,
    output logic [1:0] O_GAIN_VALID,
    output logic [3:0] O_CH0_IRANGE,
    output logic [3:0] O_CH1_IRANGE,
    output logic [1:0] O_IRANGE_VALID,
    output logic [1:0] O_CH0_FUNC,
    output logic [1:0] O_CH1_FUNC,
    output logic [1:0] O_FUNC_VALID,
    output logic [1:0] O_CMP_ENABLE,
    output logic [1:0] O_CMP_RESULT,
    output logic [1:0] O_PIN_ROUTE,
    output logic [1:0] O_PIN_OPEN_DRAIN,
    output logic [1:0] O_FEEDBACK_DIVIDER,
    output logic [11:0] O_CH0_THRESHOLD,
    output logic [11:0] O_CH1_THRESHOLD
);
    localparam int NREG = 10;
    logic [15:0] regs_reg [NREG];
    logic [15:0] rdata_reg;
    logic [NREG-1:0] hit;
    logic [15:0] mask [NREG];
    logic [7:0] addr_of [NREG];
    logic [15:0] code_mask;

    assign code_mask = (NARROW != 0) ? 16'(cfg_pkg::MASK_CODE << cfg_pkg::NARROW_DROP) :
        cfg_pkg::MASK_CODE;

    assign addr_of[0] = cfg_pkg::ADDR_CH0_HIGH;
    assign addr_of[1] = cfg_pkg::ADDR_CH0_LOW;
    assign addr_of[2] = cfg_pkg::ADDR_CH0_GAIN_CMP;
    assign addr_of[3] = cfg_pkg::ADDR_CH0_IRANGE;
    assign addr_of[4] = cfg_pkg::ADDR_CH0_CMP_FUNC;
    assign addr_of[5] = cfg_pkg::ADDR_CH1_HIGH;
    assign addr_of[6] = cfg_pkg::ADDR_CH1_LOW;
    assign addr_of[7] = cfg_pkg::ADDR_CH1_GAIN_CMP;
    assign addr_of[8] = cfg_pkg::ADDR_CH1_IRANGE;
    assign addr_of[9] = cfg_pkg::ADDR_CH1_CMP_FUNC;
    assign mask[0] = code_mask;
    assign mask[1] = code_mask;
    assign mask[2] = cfg_pkg::MASK_GAIN_CMP;
    assign mask[3] = cfg_pkg::MASK_IRANGE;
    assign mask[4] = cfg_pkg::MASK_CMP_FUNC;
    assign mask[5] = code_mask;
    assign mask[6] = code_mask;
    assign mask[7] = cfg_pkg::MASK_GAIN_CMP;
    assign mask[8] = cfg_pkg::MASK_IRANGE;
    assign mask[9] = cfg_pkg::MASK_CMP_FUNC;

    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : gen_reg
            assign hit[g] = (BUS.addr == addr_of[g]);
            always_ff @(posedge I_CLK or negedge I_RST_B) begin
                if (!I_RST_B) begin
                    regs_reg[g] <= cfg_pkg::RESET_VALUE;
                end else if (BUS.wr && hit[g]) begin
                    regs_reg[g] <= BUS.wdata & mask[g];
                end
            end
        end
    endgenerate

    logic [15:0] rd_next;
    always_comb begin
        rd_next = cfg_pkg::RESET_VALUE;
        for (int i = 0; i < NREG; i++) begin
            if (hit[i]) begin
                rd_next = regs_reg[i];
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rdata_reg <= cfg_pkg::RESET_VALUE;
        end else if (BUS.rd) begin
            rdata_reg <= rd_next;
        end
    end
    assign BUS.rdata = rdata_reg;

    assign O_CH0_UPPER_CODE = regs_reg[0][cfg_pkg::CODE_MSB:cfg_pkg::CODE_LSB];
    assign O_CH0_LOWER_CODE = regs_reg[1][cfg_pkg::CODE_MSB:cfg_pkg::CODE_LSB];
    assign O_CH1_UPPER_CODE = regs_reg[5][cfg_pkg::CODE_MSB:cfg_pkg::CODE_LSB];
    assign O_CH1_LOWER_CODE = regs_reg[6][cfg_pkg::CODE_MSB:cfg_pkg::CODE_LSB];

    function automatic logic gain_ok(input logic [2:0] g3);
        return g3 <= 3'(cfg_pkg::GAIN_4X_INT);
    endfunction
    function automatic logic irange_ok(input logic [3:0] r4);
        return r4 >= 4'(cfg_pkg::IRANGE_25UA) && r4 <= 4'(cfg_pkg::IRANGE_250UA);
    endfunction

    assign O_CH0_GAIN = regs_reg[2][cfg_pkg::GAIN_MSB:cfg_pkg::GAIN_LSB];
    assign O_CH1_GAIN = regs_reg[7][cfg_pkg::GAIN_MSB:cfg_pkg::GAIN_LSB];
    assign O_GAIN_VALID = {gain_ok(O_CH1_GAIN), gain_ok(O_CH0_GAIN)};
    assign O_CH0_IRANGE = regs_reg[3][cfg_pkg::IRANGE_MSB:cfg_pkg::IRANGE_LSB];
    assign O_CH1_IRANGE = regs_reg[8][cfg_pkg::IRANGE_MSB:cfg_pkg::IRANGE_LSB];
    assign O_IRANGE_VALID = {irange_ok(O_CH1_IRANGE), irange_ok(O_CH0_IRANGE)};
    assign O_CH0_FUNC = regs_reg[4][cfg_pkg::FUNC_MSB:cfg_pkg::FUNC_LSB];
    assign O_CH1_FUNC = regs_reg[9][cfg_pkg::FUNC_MSB:cfg_pkg::FUNC_LSB];
    function automatic logic func_ok(input logic [1:0] f2);
        return f2 <= 2'(cfg_pkg::FUNC_WINDOW);
    endfunction
    assign O_FUNC_VALID = {func_ok(O_CH1_FUNC), func_ok(O_CH0_FUNC)};

    logic [15:0] gc [2];
    assign gc[0] = regs_reg[2];
    assign gc[1] = regs_reg[7];
    generate
        for (g = 0; g < cfg_pkg::CH_COUNT; g++) begin : gen_ch
            assign O_CMP_ENABLE[g] = gc[g][cfg_pkg::BIT_ENABLE];
            assign O_PIN_ROUTE[g] = gc[g][cfg_pkg::BIT_PIN_ROUTE] & gc[g][cfg_pkg::BIT_ENABLE];
            assign O_PIN_OPEN_DRAIN[g] = gc[g][cfg_pkg::BIT_OPEN_DRAIN] & O_PIN_ROUTE[g];
            assign O_FEEDBACK_DIVIDER[g] = gc[g][cfg_pkg::BIT_DIVIDER];
        end
    endgenerate

    typedef enum logic {
        PH_LOWER,
        PH_UPPER
    } phase_e;

    // Each window bound is shown for this many cycles before the raw level is taken.
    // It must outlast the threshold register, the analog path and both synchroniser stages.
    localparam int DWELL = 8;
    localparam logic [2:0] DWELL_LAST = 3'(DWELL - 1);

    logic [1:0] raw_meta_reg;
    logic [1:0] raw_sync_reg;
    logic [11:0] upper_code [2];
    logic [11:0] lower_code [2];
    logic [1:0] func_code [2];
    logic [11:0] thr_q [2];

    assign upper_code[0] = O_CH0_UPPER_CODE;
    assign upper_code[1] = O_CH1_UPPER_CODE;
    assign lower_code[0] = O_CH0_LOWER_CODE;
    assign lower_code[1] = O_CH1_LOWER_CODE;
    assign func_code[0] = O_CH0_FUNC;
    assign func_code[1] = O_CH1_FUNC;
    assign O_CH0_THRESHOLD = thr_q[0];
    assign O_CH1_THRESHOLD = thr_q[1];

    // The raw level says the feedback lies above the shown threshold and is asynchronous.
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            raw_meta_reg <= '0;
            raw_sync_reg <= '0;
        end else begin
            raw_meta_reg <= I_CMP_RAW;
            raw_sync_reg <= raw_meta_reg;
        end
    end

    generate
        for (g = 0; g < cfg_pkg::CH_COUNT; g++) begin : gen_cmp
            phase_e phase_reg;
            phase_e phase_next;
            logic [2:0] dwell_reg;
            logic [2:0] dwell_next;
            logic hys_mode;
            logic win_mode;
            logic dwell_done;
            logic above_low_reg;
            logic above_low_next;
            logic above_high_reg;
            logic above_high_next;
            logic level_next;
            logic result_reg;
            logic [11:0] hys_thr;
            logic [11:0] win_thr;
            logic [11:0] thr_reg;
            logic [11:0] thr_next;

            assign hys_mode = func_code[g] == 2'(cfg_pkg::FUNC_HYSTERESIS);
            assign win_mode = func_code[g] == 2'(cfg_pkg::FUNC_WINDOW);
            assign dwell_done = dwell_reg == DWELL_LAST;
            assign dwell_next = (win_mode && !dwell_done) ? dwell_reg + 3'h1 : '0;
            assign phase_next = !win_mode ? PH_LOWER :
                !dwell_done ? phase_reg :
                (phase_reg == PH_LOWER) ? PH_UPPER : PH_LOWER;
            assign above_low_next = (win_mode && dwell_done && phase_reg == PH_LOWER) ?
                raw_sync_reg[g] : above_low_reg;
            assign above_high_next = (win_mode && dwell_done && phase_reg == PH_UPPER) ?
                raw_sync_reg[g] : above_high_reg;
            assign level_next = win_mode ? (above_low_reg & ~above_high_reg) : raw_sync_reg[g];
            assign hys_thr = level_next ? lower_code[g] : upper_code[g];
            assign win_thr = (phase_next == PH_UPPER) ? upper_code[g] : lower_code[g];
            // Plain mode compares against the lower margin code, the same bound for either output level.
            assign thr_next = win_mode ? win_thr : hys_mode ? hys_thr : lower_code[g];

            always_ff @(posedge I_CLK or negedge I_RST_B) begin
                if (!I_RST_B) begin
                    phase_reg <= PH_LOWER;
                    dwell_reg <= '0;
                    above_low_reg <= 1'b0;
                    above_high_reg <= 1'b0;
                    result_reg <= 1'b0;
                    thr_reg <= '0;
                end else begin
                    phase_reg <= phase_next;
                    dwell_reg <= dwell_next;
                    above_low_reg <= above_low_next;
                    above_high_reg <= above_high_next;
                    result_reg <= level_next ^ gc[g][cfg_pkg::BIT_INVERT];
                    thr_reg <= thr_next;
                end
            end
            assign thr_q[g] = thr_reg;
            assign O_CMP_RESULT[g] = result_reg;
        end
    endgenerate
endmodule
`default_nettype wire

// ### cfg_host.sv
`timescale 1ns/10ps
`default_nettype none
module cfg_host (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    cfg_if.host BUS,
    input wire logic [7:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [15:0] O_RDATA,
    output logic O_RVALID
);
    logic rd_d_reg;
    assign BUS.addr = I_ADDR;
    assign BUS.wdata = I_WDATA;
    // invalid codes are the caller's duty
    assign BUS.wr = I_WR;
    assign BUS.rd = I_RD & ~I_WR;
    assign O_RDATA = BUS.rdata;
    assign O_RVALID = rd_d_reg;
    // enable order is the caller's duty
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rd_d_reg <= 1'b0;
        end else begin
            rd_d_reg <= BUS.rd;
        end
    end
endmodule
`default_nettype wire

// ### cfg_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
module cfg_chk (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata
);
    wire logic gc = addr inside {8'h03, 8'h15};
    wire logic ir = addr inside {8'h04, 8'h16};
    wire logic fn = addr inside {8'h05, 8'h17};
    wire logic cd = addr inside {8'h01, 8'h02, 8'h13, 8'h14};
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    property p_gc_mask;
        rd && gc |=> (rdata & 16'hE3E0) == 16'h0000;
    endproperty
    a_gc_mask: assert property (p_gc_mask) else $error("gain bits");
    property p_ir_mask;
        rd && ir |=> (rdata & 16'hE1FF) == 16'h0000;
    endproperty
    a_ir_mask: assert property (p_ir_mask) else $error("range bits");
    property p_fn_mask;
        rd && fn |=> (rdata & 16'hF3FF) == 16'h0000;
    endproperty
    a_fn_mask: assert property (p_fn_mask) else $error("function bits");
    property p_code_low;
        rd && cd |=> rdata[3:0] == 4'h0;
    endproperty
    a_code_low: assert property (p_code_low) else $error("code low bits");
    property p_unmapped;
        rd && !(gc || ir || fn || cd) |=> rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_hold;
        !rd |=> $stable(rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_gc_back;
        wr && gc ##1 rd && addr == $past(addr) |=> rdata == ($past(wdata, 2) & 16'h1C1F);
    endproperty
    a_gc_back: assert property (p_gc_back) else $error("gain readback");
    property p_ir_back;
        wr && ir ##1 rd && addr == $past(addr) |=> rdata == ($past(wdata, 2) & 16'h1E00);
    endproperty
    a_ir_back: assert property (p_ir_back) else $error("range readback");
    property p_fn_back;
        wr && fn ##1 rd && addr == $past(addr) |=> rdata == ($past(wdata, 2) & 16'h0C00);
    endproperty
    a_fn_back: assert property (p_fn_back) else $error("function readback");
endmodule
`default_nettype wire

// ### dual_channel_output_comparator_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dual_channel_output_comparator_config_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] cmp_raw = 2'h0;
    logic [15:0] rdata;
    logic rvalid;
    logic [11:0] up0, lo0, up1, lo1;
    logic [2:0] g0, g1;
    logic [3:0] r0, r1;
    logic [1:0] f0, f1, gv, rv, fv, en, res, rte, od, div;
    logic [11:0] fb0 = 12'h000;
    logic [11:0] th0, th1;
    localparam logic [11:0] HF [4] = '{12'h600, 12'h900, 12'h600, 12'h200};
    localparam logic [15:0] HT [4] = '{16'h0800, 16'h0400, 16'h0400, 16'h0800};
    localparam logic [15:0] HR [4] = '{16'h0000, 16'h0001, 16'h0001, 16'h0000};
    localparam logic [11:0] WF [3] = '{12'h600, 12'h900, 12'h200};
    localparam logic [15:0] WR [3] = '{16'h0001, 16'h0000, 16'h0000};
    int failures = 0;
    int num_checks = 0;
    localparam logic [7:0] AD [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
        8'h13, 8'h14, 8'h15, 8'h16, 8'h17};
    localparam logic [15:0] MK [10] = '{16'hFFF0, 16'hFFF0, 16'h1C1F, 16'h1E00, 16'h0C00,
        16'hFFF0, 16'hFFF0, 16'h1C1F, 16'h1E00, 16'h0C00};
    localparam logic [15:0] CW [5] = '{16'h0019, 16'h0018, 16'h0012, 16'h000F, 16'h0013};
    // Bit 5 is the raw comparator level, bits 4:0 are enable, route, open drain, divider, result.
    localparam logic [5:0] CE [5] = '{6'h1C, 6'h21, 6'h20, 6'h1B, 6'h11};
    cfg_if bus_if();
    cfg_host cfg_host_i(.I_CLK(clk), .I_RST_B(rst_b), .BUS(bus_if.host), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_RVALID(rvalid));
    cfg_device cfg_device_i(.I_CLK(clk), .I_RST_B(rst_b), .BUS(bus_if.device),
        .I_CMP_RAW(cmp_raw), .O_CH0_UPPER_CODE(up0), .O_CH0_LOWER_CODE(lo0),
        .O_CH1_UPPER_CODE(up1), .O_CH1_LOWER_CODE(lo1), .O_CH0_GAIN(g0), .O_CH1_GAIN(g1),
        .O_GAIN_VALID(gv), .O_CH0_IRANGE(r0), .O_CH1_IRANGE(r1), .O_IRANGE_VALID(rv),
        .O_CH0_FUNC(f0), .O_CH1_FUNC(f1), .O_FUNC_VALID(fv), .O_CMP_ENABLE(en),
        .O_CMP_RESULT(res), .O_PIN_ROUTE(rte), .O_PIN_OPEN_DRAIN(od), .O_FEEDBACK_DIVIDER(div),
        .O_CH0_THRESHOLD(th0), .O_CH1_THRESHOLD(th1));
    cfg_chk cfg_chk_i(.I_CLK(clk), .I_RST_B(rst_b), .addr(bus_if.addr), .wdata(bus_if.wdata),
        .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata));
    always #20 clk = ~clk;
    // Stand-in for the analog comparator: feedback level above the shown threshold.
    always @(posedge clk) begin
        cmp_raw <= {1'b0, fb0 > th0};
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_t(input logic [7:0] a, input logic [15:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_t(input logic [7:0] a, input logic [15:0] e);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
        chk(16'(rvalid), 16'h0001);
        @(posedge clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 10; k++) rd_t(AD[k], 16'h0000);
        chk(16'({gv, rv, fv}), 16'h0033);
        for (int k = 0; k < 10; k++) begin
            wr_t(AD[k], 16'hFFFF);
            rd_t(AD[k], MK[k]);
        end
        chk(16'(up0), 16'h0FFF);
        chk(16'(lo1), 16'h0FFF);
        chk(16'({g1, r0, f1}), 16'h01FF);
        chk(16'({en[1], rte[1], od[1], div[1], res[1]}), 16'h001F);
        chk(16'(th1), 16'h0FFF);
        wr_t(8'h14, 16'hA5C7);
        rd_t(8'h14, 16'hA5C0);
        chk(16'(lo0), 16'h0A5C);
        wr_t(8'h01, 16'h5A3F);
        rd_t(8'h01, 16'h5A30);
        chk(16'(up1), 16'h05A3);
        wr_t(8'h06, 16'hFFFF);
        rd_t(8'h06, 16'h0000);
        for (int g = 0; g < 8; g++) begin
            wr_t(8'h15, 16'(g) << 10);
            rd_t(8'h15, 16'(g) << 10);
            chk(16'(g0), 16'(g));
            chk(16'(gv[0]), 16'(g < 6));
        end
        for (int r = 0; r < 16; r++) begin
            wr_t(8'h04, 16'(r) << 9);
            rd_t(8'h04, 16'(r) << 9);
            chk(16'(r1), 16'(r));
            chk(16'(rv[1]), 16'(r > 7 && r < 12));
        end
        for (int f = 0; f < 4; f++) begin
            wr_t(8'h17, 16'(f) << 10);
            rd_t(8'h17, 16'(f) << 10);
            chk(16'(f0), 16'(f));
            chk(16'(fv[0]), 16'(f != 3));
        end
        wr_t(8'h17, 16'h0000);
        rd_t(8'h17, 16'h0000);
        for (int c = 0; c < 5; c++) begin
            fb0 <= CE[c][5] ? 12'hFFF : 12'h000;
            wr_t(8'h15, CW[c]);
            rd_t(8'h15, CW[c]);
            repeat (2) @(posedge clk);
            chk(16'({en[0], rte[0], od[0], div[0], res[0]}), 16'(CE[c][4:0]));
        end
        wr_t(8'h13, 16'h8000);
        rd_t(8'h13, 16'h8000);
        wr_t(8'h14, 16'h4000);
        rd_t(8'h14, 16'h4000);
        wr_t(8'h15, 16'h0001);
        rd_t(8'h15, 16'h0001);
        wr_t(8'h17, 16'h0400);
        rd_t(8'h17, 16'h0400);
        for (int h = 0; h < 4; h++) begin
            fb0 <= HF[h];
            repeat (8) @(posedge clk);
            chk(16'(th0), HT[h]);
            chk(16'(res[0]), HR[h]);
        end
        wr_t(8'h17, 16'h0800);
        rd_t(8'h17, 16'h0800);
        for (int w = 0; w < 3; w++) begin
            fb0 <= WF[w];
            repeat (40) @(posedge clk);
            chk(16'(res[0]), WR[w]);
        end
        fb0 <= 12'h000;
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd_t(8'h17, 16'h0000);
        rd_t(8'h16, 16'h0000);
        rd_t(8'h15, 16'h0000);
        chk(16'({res[0], th0}), 16'h0000);
        conclude();
    end
endmodule
`default_nettype wire
